// [rtl/arc_defs.svh]
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ARC_OFS_MODE 4'h0
`define ARC_OFS_CONFIG 4'h1
`define ARC_OFS_STATUS 4'h2
`define ARC_OFS_DATA 4'h3

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ARC_MODE_FS_LSB 5
`define ARC_MODE_RST 15'h0c02
`define ARC_CONFIG_RST 6'h20
`define ARC_STATUS_APPEND_LSB 24

// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define ARC_CLK_MHZ 10
`define ARC_RESET_WAIT_US 500
`define ARC_RESET_ONES 6'd40
`define ARC_SETTLE_PERIODS 3'd4
`define ARC_MCLK_PER_FS 1024
`define ARC_SYNC_MIN_MCLK 4
`define ARC_TEMP_ZERO 24'h800000
`define ARC_TEMP_SLOPE 12'd2815
`define ARC_SYNC_PIN_RST 5'h05

`endif

// [rtl/arc_pkg.sv]
package arc_pkg;

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CLK_XTAL = 2'b00,
    CLK_EXT = 2'b01,
    CLK_INT = 2'b10,
    CLK_INT_OUT = 2'b11
  } arc_clk_src_e;

  typedef enum logic [2:0] {
    FLT_HELD = 3'b000,
    FLT_ARMED = 3'b001,
    FLT_SETTLE = 3'b010,
    FLT_RUN = 3'b011,
    FLT_IDLE = 3'b100
  } arc_flt_state_e;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [9:0] fs;
    logic start_mode;
    logic status_append;
    logic parity_enable;
    arc_clk_src_e clk_src;
  } arc_mode_s;

  typedef struct packed {
    logic bipolar;
    logic temp_sensor_select;
    logic [3:0] channel;
  } arc_config_s;

  typedef struct packed {
    logic ready_n;
    logic [1:0] rsvd;
    logic parity;
    logic [3:0] channel;
  } arc_status_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } arc_bus_req_s;

endpackage : arc_pkg

// [rtl/arc_pin_sync.sv]
`timescale 1ns/1ns
module arc_pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule : arc_pin_sync

// [rtl/arc_control.sv]
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "arc_defs.svh"

module arc_control #(
  parameter int RESET_WAIT_CYC = `ARC_RESET_WAIT_US * `ARC_CLK_MHZ,
  parameter int MCLK_DIV = 1,
  parameter int MCLK_PER_FS = `ARC_MCLK_PER_FS
) (
  input wire logic clk,
  input wire logic reset_n,
  input arc_pkg::arc_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  input wire logic sclk_pin,
  input wire logic din_pin,
  input wire logic sync_n_pin,
  input wire logic crystal_in_pin,
  input wire logic clock_io_pin_in,
  output logic clock_io_pin_out,
  output logic clock_io_pin_oe,
  input wire logic [23:0] analog_code,
  input wire logic [9:0] temp_kelvin,
  output logic ready_n,
  output logic filter_hold,
  output logic temp_route,
  output logic reset_busy
);

  import arc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic even_parity(input logic [23:0] word);
    even_parity = ^word;
  endfunction : even_parity

  function automatic logic [23:0] temp_code(input logic [9:0] kelvin);
    logic [21:0] prod;
    prod = kelvin * `ARC_TEMP_SLOPE;
    temp_code = `ARC_TEMP_ZERO + {2'h0, prod};
  endfunction : temp_code

  localparam int BW = $clog2(RESET_WAIT_CYC + 1);
  localparam int DW = (MCLK_DIV > 1) ? $clog2(MCLK_DIV) : 1;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic sclk_rise;
  logic din_lvl;
  logic sync_lvl;
  logic sync_fall;
  logic [5:0] ones_q;
  logic ones_hit;
  logic ones_hit_q;
  logic rst_all;
  logic [BW-1:0] busy_cnt_q;
  arc_mode_s mode_q;
  arc_config_s config_q;
  logic [DW-1:0] div_cnt_q;
  logic int_mclk_q;
  logic mclk_cur;
  logic mclk_prev_q;
  logic mclk_fall;
  arc_flt_state_e flt_q;
  logic [19:0] per_cnt_q;
  logic [19:0] per_len;
  logic [9:0] fs_eff;
  logic period_done;
  logic [2:0] settle_q;
  logic emit;
  logic [23:0] data_q;
  logic [3:0] chan_q;
  arc_status_s status;
  logic data_rd;
  logic wr_mode;
  logic wr_config;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  arc_pin_sync #(
    .WIDTH(5),
    .RST_VAL(`ARC_SYNC_PIN_RST)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({clock_io_pin_in, crystal_in_pin, sync_n_pin, din_pin, sclk_pin}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign din_lvl = pin_lvl[1];
  assign sync_lvl = pin_lvl[2];
  assign sync_fall = pin_fall[2];

  // ----------------------------------------
  // Serial reset detector
  // ----------------------------------------
  assign ones_hit = sclk_rise && din_lvl && (ones_q == `ARC_RESET_ONES - 6'd1);

  always_ff @(posedge clk) begin
    if (rst_all) begin
      ones_q <= 6'h00;
    end else if (sclk_rise) begin
      if (din_lvl) begin
        ones_q <= ones_q + 6'd1;
      end else begin
        ones_q <= 6'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ones_hit_q <= 1'b0;
    end else begin
      ones_hit_q <= ones_hit;
    end
  end

  // Pin reset and serial reset act alike
  assign rst_all = !reset_n || ones_hit_q;

  // Busy window so a host can poll instead of timing
  always_ff @(posedge clk) begin
    if (rst_all) begin
      busy_cnt_q <= BW'(RESET_WAIT_CYC);
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - BW'(1);
    end
  end

  assign reset_busy = (busy_cnt_q != '0);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_mode = bus_req.wr && (bus_req.addr == `ARC_OFS_MODE);
  assign wr_config = bus_req.wr && (bus_req.addr == `ARC_OFS_CONFIG);

  // Sync never touches these
  always_ff @(posedge clk) begin
    if (rst_all) begin
      mode_q <= `ARC_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= bus_req.wdata[14:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      config_q <= `ARC_CONFIG_RST;
    end else if (wr_config) begin
      config_q <= bus_req.wdata[5:0];
    end
  end

  assign temp_route = config_q.temp_sensor_select;

  // ----------------------------------------
  // Master clock
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst_all) begin
      div_cnt_q <= '0;
      int_mclk_q <= 1'b0;
    end else if (div_cnt_q == DW'(MCLK_DIV - 1)) begin
      div_cnt_q <= '0;
      int_mclk_q <= !int_mclk_q;
    end else begin
      div_cnt_q <= div_cnt_q + DW'(1);
    end
  end

  always_comb begin
    unique case (mode_q.clk_src)
      CLK_XTAL: mclk_cur = pin_lvl[3];
      CLK_EXT: mclk_cur = pin_lvl[4];
      CLK_INT: mclk_cur = int_mclk_q;
      CLK_INT_OUT: mclk_cur = int_mclk_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= mclk_cur;
    end
  end

  assign mclk_fall = mclk_prev_q && !mclk_cur;

  // Pin is driven only when sharing the internal clock
  always_ff @(posedge clk) begin
    if (rst_all) begin
      clock_io_pin_oe <= 1'b0;
      clock_io_pin_out <= 1'b0;
    end else begin
      clock_io_pin_oe <= (mode_q.clk_src == CLK_INT_OUT);
      clock_io_pin_out <= int_mclk_q;
    end
  end

  // ----------------------------------------
  // Conversion period
  // ----------------------------------------
  // A zero rate word would stall, so it counts as one
  assign fs_eff = (mode_q.fs == 10'h000) ? 10'h001 : mode_q.fs;
  assign per_len = 20'(MCLK_PER_FS) * {10'h000, fs_eff};
  assign period_done = mclk_fall && (per_cnt_q >= per_len - 20'd1);

  always_ff @(posedge clk) begin
    if (rst_all || flt_q == FLT_HELD || flt_q == FLT_ARMED) begin
      per_cnt_q <= 20'h00000;
    end else if (flt_q == FLT_IDLE) begin
      per_cnt_q <= 20'h00000;
    end else if (period_done) begin
      per_cnt_q <= 20'h00000;
    end else if (mclk_fall) begin
      per_cnt_q <= per_cnt_q + 20'd1;
    end
  end

  // ----------------------------------------
  // Filter and modulator sequencing
  // ----------------------------------------
  assign emit = period_done && !sync_fall && ((flt_q == FLT_RUN) ||
    (flt_q == FLT_SETTLE && settle_q == `ARC_SETTLE_PERIODS - 3'd1));

  always_ff @(posedge clk) begin
    if (rst_all) begin
      flt_q <= FLT_SETTLE;
    end else if (sync_fall) begin
      flt_q <= FLT_HELD;
    end else begin
      unique case (flt_q)
        FLT_HELD: begin
          if (sync_lvl) begin
            flt_q <= FLT_ARMED;
          end
        end
        FLT_ARMED: begin
          if (mclk_fall) begin
            flt_q <= FLT_SETTLE;
          end
        end
        FLT_SETTLE: begin
          if (emit) begin
            flt_q <= mode_q.start_mode ? FLT_IDLE : FLT_RUN;
          end
        end
        FLT_RUN: begin
          if (mode_q.start_mode && emit) begin
            flt_q <= FLT_IDLE;
          end
        end
        FLT_IDLE: begin
          flt_q <= FLT_IDLE;
        end
        default: begin
          flt_q <= FLT_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all || flt_q != FLT_SETTLE) begin
      settle_q <= 3'd0;
    end else if (period_done) begin
      settle_q <= settle_q + 3'd1;
    end
  end

  assign filter_hold = (flt_q == FLT_HELD) || (flt_q == FLT_ARMED);

  // ----------------------------------------
  // Result capture and ready
  // ----------------------------------------
  // Only the bipolar sensor code is meaningful
  always_ff @(posedge clk) begin
    if (rst_all) begin
      data_q <= 24'h000000;
      chan_q <= 4'h0;
    end else if (emit) begin
      if (config_q.temp_sensor_select) begin
        data_q <= temp_code(temp_kelvin);
      end else begin
        data_q <= analog_code;
      end
      chan_q <= config_q.channel;
    end
  end

  assign data_rd = bus_req.rd && (bus_req.addr == `ARC_OFS_DATA);

  // New result wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ready_n <= 1'b1;
    end else if (emit) begin
      ready_n <= 1'b0;
    end else if (data_rd || sync_fall) begin
      ready_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // Status and read data
  // ----------------------------------------
  always_comb begin
    status.ready_n = ready_n;
    status.rsvd = 2'b00;
    status.parity = mode_q.parity_enable && even_parity(data_q);
    status.channel = chan_q;
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ARC_OFS_MODE: bus_rdata <= {17'h00000, mode_q};
        `ARC_OFS_CONFIG: bus_rdata <= {26'h0000000, config_q};
        `ARC_OFS_STATUS: bus_rdata <= {24'h000000, status};
        `ARC_OFS_DATA: begin
          if (mode_q.status_append) begin
            bus_rdata <= {status, data_q};
          end else begin
            bus_rdata <= {8'h00, data_q};
          end
        end
        default: bus_rdata <= 32'h00000000;
      endcase
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

endmodule : arc_control

// [dv/arc_checker.sv]
`timescale 1ns/1ns
module arc_chk #(
  parameter int RESET_WAIT_CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input arc_pkg::arc_bus_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic sync_n_pin,
  input wire logic clock_io_pin_oe,
  input wire logic ready_n,
  input wire logic filter_hold,
  input wire logic temp_route,
  input wire logic reset_busy
);
  import arc_pkg::*;
  localparam int WAIT_MAX = RESET_WAIT_CYC + 4;
  logic par_q;

  // ----
  // Shadow of parity plus append, dropped on any full reset
  // ----
  always_ff @(posedge clk) begin
    if (!reset_n || $rose(reset_busy)) begin
      par_q <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == 4'h0) begin
      par_q <= &bus_req.wdata[3:2];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_HOLD_IN_SYNC: assert property (!sync_n_pin [*4] |-> filter_hold)
    else $error("filter not held while restart low");
  AST_HOLD_NO_READY: assert property (filter_hold [*2] |-> ready_n)
    else $error("result flagged while filter held");
  AST_BUSY_SPAN: assert property ($rose(reset_n) |-> reset_busy [*8] ##[1:WAIT_MAX] !reset_busy)
    else $error("reset wait span wrong");
  AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_PARITY_EVEN: assert property (par_q && bus_req.rd && bus_req.addr == 4'h3
    |=> ^{bus_rdata[23:0], bus_rdata[28]} == 1'b0)
    else $error("odd ones in conversion read");
  AST_CLK_DRIVE: assert property (bus_req.wr && bus_req.addr == 4'h0 ##1 !bus_req.wr
    |=> clock_io_pin_oe == ($past(bus_req.wdata[1:0], 2) == 2'b11))
    else $error("clock pin drive mismatch");
  AST_TEMP_ROUTE: assert property (bus_req.wr && bus_req.addr == 4'h1
    |=> temp_route == $past(bus_req.wdata[4]))
    else $error("sensor routing mismatch");
  AST_READY_STANDS: assert property ((sync_n_pin [*5]) ##0
    (!ready_n && !reset_busy && !(bus_req.rd && bus_req.addr == 4'h3))
    |=> !ready_n || reset_busy)
    else $error("ready dropped without cause");
endmodule : arc_chk

// [dv/arc_host.sv]
`timescale 1ns/1ns
module arc_host (
  input wire logic clk,
  input wire logic mclk,
  output logic sclk_pin,
  output logic din_pin,
  output logic sync_n_pin
);
  initial begin
    sclk_pin = 1'b1;
    din_pin = 1'b0;
    sync_n_pin = 1'b1;
  end

  // ----
  // Serial clock idles high, runs only within a frame
  // ----
  task automatic send_bits(input int n, input logic v);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
      din_pin <= v;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b1;
    end
    repeat (4) @(posedge clk);
    din_pin <= 1'b0;
  endtask : send_bits

  task automatic restart(input int lo_cyc);
    @(posedge clk);
    sync_n_pin <= 1'b0;
    repeat (lo_cyc) @(posedge clk);
    for (int i = 0; i < 8 && mclk !== 1'b0; i++) @(posedge clk);
    for (int i = 0; i < 8 && mclk !== 1'b1; i++) @(posedge clk);
    sync_n_pin <= 1'b1;
  endtask : restart
endmodule : arc_host

// [dv/adc_reset_sync_parity_control_bench.sv]
`timescale 1ns/1ns
module adc_reset_sync_parity_control_bench;
  import arc_pkg::*;
  logic clk;
  logic reset_n = 1'b0;
  arc_bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  logic sclk;
  logic din;
  logic sync_n;
  logic xtal;
  logic [1:0] xdiv = 2'h0;
  logic cio_in;
  logic cio_out;
  logic cio_oe;
  logic [23:0] code = 24'h5aa5c3;
  logic [9:0] kelvin = 10'd300;
  logic ready_n;
  logic filter_hold;
  logic temp_route;
  logic reset_busy;
  int error_cnt = 0;
  int samples_checked = 0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Crystal runs slower than the internal clock so the source shows in timing
  always @(posedge clk) xdiv <= xdiv + 2'h1;
  assign xtal = xdiv[1];
  // External clock shares the pin whenever the part is not driving it
  assign cio_in = cio_oe ? cio_out : xtal;

  arc_control #(.RESET_WAIT_CYC(20), .MCLK_PER_FS(2)) DUT (.clk(clk), .reset_n(reset_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .sclk_pin(sclk), .din_pin(din),
    .sync_n_pin(sync_n), .crystal_in_pin(xtal), .clock_io_pin_in(cio_in),
    .clock_io_pin_out(cio_out), .clock_io_pin_oe(cio_oe), .analog_code(code),
    .temp_kelvin(kelvin), .ready_n(ready_n), .filter_hold(filter_hold),
    .temp_route(temp_route), .reset_busy(reset_busy));
  arc_host host (.clk(clk), .mclk(cio_out), .sclk_pin(sclk), .din_pin(din),
    .sync_n_pin(sync_n));

  // ----
  // Access tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  task automatic wait_rdy(output int n);
    for (n = 0; n < 400 && ready_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_rdy

  task automatic wait_idle();
    for (int i = 0; i < 100 && reset_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_idle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  // ----
  // Tests
  // ----
  initial begin : main
    logic [31:0] v;
    logic [23:0] t;
    int n;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wait_idle();
    check(32'(reset_busy), 32'h0);
    rd(4'h0, v);
    check(v, 32'h0c02);
    rd(4'h1, v);
    check(v, 32'h20);
    rd(4'hf, v);
    check(v, 32'h0);
    $display("reset values done");
    wr(4'h0, 32'h2e);
    for (int k = 0; k < 2; k++) begin
      wr(4'h1, k ? 32'h33 : 32'h02);
      check(32'(temp_route), 32'(k));
      rd(4'h3, v);
      wait_rdy(n);
      rd(4'h3, v);
      t = k ? 24'h800000 + 24'd2815 * 24'd300 : 24'h5aa5c3;
      check(v, {3'b000, ^t, (k ? 4'h3 : 4'h2), t});
      check(32'(^{v[28], v[23:0]}), 32'h0);
    end
    $display("parity and sensor done");
    fork
      host.restart(12);
      begin
        repeat (6) @(posedge clk);
        #1 check(32'(filter_hold), 32'h1);
        check(32'(ready_n), 32'h1);
      end
    join
    wait_rdy(n);
    check(32'(n >= 16), 32'h1);
    check(32'(filter_hold), 32'h0);
    rd(4'h0, v);
    check(v, 32'h2e);
    wr(4'h0, 32'h3e);
    host.restart(12);
    wait_rdy(n);
    rd(4'h3, v);
    repeat (60) @(posedge clk);
    #1 check(32'(ready_n), 32'h1);
    $display("restart done");
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 32'h2c | s);
      @(posedge clk);
      #1 check(32'(cio_oe), 32'(s == 3));
      host.restart(20);
      wait_rdy(n);
      check(32'(ready_n), 32'h0);
      check(32'(n >= 28), 32'(s < 2));
    end
    $display("clock sources done");
    host.send_bits(39, 1'b1);
    host.send_bits(1, 1'b0);
    host.send_bits(39, 1'b1);
    rd(4'h0, v);
    check(v, 32'h2f);
    host.send_bits(1, 1'b0);
    host.send_bits(40, 1'b1);
    #1 check(32'(reset_busy), 32'h1);
    wait_idle();
    rd(4'h0, v);
    check(v, 32'h0c02);
    rd(4'h1, v);
    check(v, 32'h20);
    $display("serial reset done");
    wrap_up();
  end
endmodule : adc_reset_sync_parity_control_bench

bind arc_control arc_chk #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) chk (.clk(clk), .reset_n(reset_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .sync_n_pin(sync_n_pin),
  .clock_io_pin_oe(clock_io_pin_oe), .ready_n(ready_n), .filter_hold(filter_hold),
  .temp_route(temp_route), .reset_busy(reset_busy));
